// *** core/asbc_top.sv ***
// Behaviour
// - Shock mode select high enables buffering, low disables and flushes it.
// - Samples enter at double speed, go to DRAM, leave at 1x rate.
// - Each 16-bit sample is ADPCM coded to 5 bits before storage.
// - DRAM of 256K x 4 or 1M x 4 nibbles is supported.
// - Size select high picks 1 Mbit organisation, low picks 4 Mbit.
// - Full DRAM stops writing and raises buffer overflow.
// - Stop point found with permission high raises resume found, writing restarts.
// - C2 error flag high acts as a shock: overflow and write stop.
// - Shock reset pin low initialises only the anti-shock logic.
// - Code F4 releases the shock reset, F5 asserts it, F5 at chip reset.
// - Chip reset loads all latched command settings with defaults.
// - Single-byte commands arrive from host; latched ones hold until changed.
//
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module asbc_top (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic SHOCK_MODE_SELECT,
   input wire logic DRAM_SIZE_SELECT,
   input wire logic WRITE_PERMISSION,
   input wire logic C2_ERROR_FLAG,
   input wire logic SHOCK_CTRL_RESET_N,
   input wire logic CMD_VALID,
   input wire logic [7:0] CMD_CODE,
   input wire logic IN_VALID,
   output logic IN_READY,
   input wire logic [15:0] IN_SAMPLE,
   input wire logic [asbc_pkg::ASBC_FRW-1:0] IN_FRAME,
   input wire logic OUT_READY,
   output logic OUT_VALID,
   output logic [15:0] OUT_SAMPLE,
   output logic BUFFER_OVERFLOW,
   output logic RESUME_FOUND,
   output logic [asbc_pkg::ASBC_DAW-1:0] DRAM_ADDR,
   output logic [3:0] DRAM_WDATA,
   output logic DRAM_WE,
   output logic DRAM_RE,
   input wire logic [3:0] DRAM_RDATA,
   input wire logic [asbc_pkg::ASBC_RAW-1:0] ADDR,
   input wire logic [asbc_pkg::ASBC_DW-1:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [asbc_pkg::ASBC_DW-1:0] RDATA,
   output logic IRQ
);
   import asbc_pkg::*;

   // ----------------------------------------
   // Codec step, shared by coder and decoder
   // ----------------------------------------
   function automatic logic [19:0] asbc_adapt(
      input logic [15:0] p,
      input logic [3:0] sh,
      input logic [4:0] c
   );
      logic signed [17:0] d;
      logic signed [17:0] v;
      logic [15:0] q;
      logic [3:0] s;
      d = $signed({14'h0, c[3:0]}) <<< sh;
      v = c[4] ? $signed({{2{p[15]}}, p}) - d : $signed({{2{p[15]}}, p}) + d;
      // Clamp so a long run of steep steps cannot wrap the predictor
      if (v > 18'sh07fff) begin
         q = 16'h7fff;
      end else if (v < -18'sh08000) begin
         q = 16'h8000;
      end else begin
         q = v[15:0];
      end
      s = sh;
      if (c[3:0] >= ASBC_MAG_HI && sh < ASBC_SH_MAX) begin
         s = sh + 4'h1;
      end else if (c[3:0] <= ASBC_MAG_LO && sh != 4'h0) begin
         s = sh - 4'h1;
      end
      return {s, q};
   endfunction : asbc_adapt

   // ----------------------------------------
   // State
   // ----------------------------------------
   asbc_state_s s_r;
   asbc_state_s s_nxt;
   logic [20:0] cap;
   logic [19:0] pmask;
   logic full;
   logic as_rst;
   logic rd_go;
   logic wr_go;
   logic take;
   logic enc;
   logic [2:0] ev;
   logic [2:0] clr;
   logic [19:0] dec;
   logic [19:0] nenc;
   logic signed [16:0] diff;
   logic [16:0] mag;
   logic [16:0] mag_sh;
   logic [4:0] code;
   logic keep_rel;
   logic [31:0] keep_rd;

   assign cap = DRAM_SIZE_SELECT ? ASBC_CAP_SMALL : ASBC_CAP_LARGE;
   assign pmask = 20'(cap - 21'h1);
   assign full = s_r.fill >= cap;
   // Pin and command reset combine so that a tied-low pin hands control to commands
   assign as_rst = !SHOCK_CTRL_RESET_N && !s_r.cmd_rel;
   assign IN_READY = (s_r.st == ASBC_WRITE) ? (s_r.wbits <= ASBC_NIB_BITS) : 1'b1;
   assign take = IN_VALID && IN_READY;

   always_comb begin
      s_nxt = s_r;
      ev = 3'h0;
      enc = 1'b0;
      dec = 20'h0;
      nenc = 20'h0;
      diff = 17'sh0;
      mag = 17'h0;
      mag_sh = 17'h0;
      code = 5'h0;
      keep_rel = 1'b0;
      keep_rd = 32'h0;
      s_nxt.re = 1'b0;
      s_nxt.we = 1'b0;
      s_nxt.rdata = 32'h0;
      s_nxt.pend = s_r.re;
      // ----------------------------------------
      // Read side, drained at playback rate
      // ----------------------------------------
      if (s_r.pend) begin
         s_nxt.racc = s_r.racc | (9'(DRAM_RDATA) << s_r.rbits);
         s_nxt.rbits = s_r.rbits + ASBC_NIB_BITS;
      end
      if (s_r.oval && OUT_READY) begin
         s_nxt.oval = 1'b0;
      end
      if (!s_nxt.oval && s_nxt.rbits >= ASBC_CODE_BITS) begin
         dec = asbc_adapt(s_r.dpred, s_r.dsh, s_nxt.racc[4:0]);
         s_nxt.dpred = dec[15:0];
         s_nxt.dsh = dec[19:16];
         s_nxt.osmp = dec[15:0];
         s_nxt.oval = 1'b1;
         s_nxt.racc = s_nxt.racc >> ASBC_CODE_BITS;
         s_nxt.rbits = s_nxt.rbits - ASBC_CODE_BITS;
      end
      // One DRAM access per cycle; reads win so playback never starves
      rd_go = (s_r.st != ASBC_OFF) && (s_r.fill != 21'h0) && (s_nxt.rbits <= ASBC_NIB_BITS)
         && !s_r.re && !s_r.pend;
      wr_go = !rd_go && (s_r.st == ASBC_WRITE) && (s_r.wbits >= ASBC_NIB_BITS) && !full;
      if (rd_go) begin
         s_nxt.re = 1'b1;
         s_nxt.addr = s_r.rd_ptr;
         s_nxt.rd_ptr = (s_r.rd_ptr + 20'h1) & pmask;
         s_nxt.fill = s_r.fill - 21'h1;
      end
      if (wr_go) begin
         s_nxt.we = 1'b1;
         s_nxt.addr = s_r.wr_ptr;
         s_nxt.wdat = s_r.wacc[3:0];
         s_nxt.wacc = s_r.wacc >> ASBC_NIB_BITS;
         s_nxt.wbits = s_r.wbits - ASBC_NIB_BITS;
         s_nxt.wr_ptr = (s_r.wr_ptr + 20'h1) & pmask;
         s_nxt.fill = s_r.fill + 21'h1;
      end
      // ----------------------------------------
      // Write control
      // ----------------------------------------
      unique case (s_r.st)
         ASBC_OFF: begin
            if (SHOCK_MODE_SELECT) begin
               s_nxt.st = ASBC_WRITE;
            end
         end
         ASBC_WRITE: begin
            if (C2_ERROR_FLAG) begin
               s_nxt.st = ASBC_HALT;
               s_nxt.ovf = 1'b1;
               s_nxt.res = 1'b0;
               ev[ASBC_EV_OVF] = 1'b1;
               ev[ASBC_EV_SHK] = 1'b1;
            end else if (full && s_r.wbits >= ASBC_NIB_BITS) begin
               s_nxt.st = ASBC_HALT;
               s_nxt.ovf = 1'b1;
               s_nxt.res = 1'b0;
               ev[ASBC_EV_OVF] = 1'b1;
            end else if (take) begin
               enc = 1'b1;
            end
         end
         ASBC_HALT: begin
            // Samples are dropped here; the stop point is the frame after the last stored
            if (WRITE_PERMISSION && IN_VALID && !full
                && IN_FRAME == s_r.last_fr + 8'h1) begin
               s_nxt.st = ASBC_WRITE;
               s_nxt.ovf = 1'b0;
               s_nxt.res = 1'b1;
               ev[ASBC_EV_RES] = 1'b1;
               enc = 1'b1;
            end
         end
         default: begin
            s_nxt.st = ASBC_OFF;
         end
      endcase
      // ----------------------------------------
      // Coder
      // ----------------------------------------
      if (enc) begin
         diff = $signed({IN_SAMPLE[15], IN_SAMPLE}) - $signed({s_r.epred[15], s_r.epred});
         mag = diff[16] ? 17'(-diff) : 17'(diff);
         mag_sh = mag >> s_r.esh;
         code = {diff[16], (mag_sh > 17'h0000f) ? 4'hf : mag_sh[3:0]};
         nenc = asbc_adapt(s_r.epred, s_r.esh, code);
         s_nxt.epred = nenc[15:0];
         s_nxt.esh = nenc[19:16];
         s_nxt.wacc = s_nxt.wacc | (9'(code) << s_nxt.wbits);
         s_nxt.wbits = s_nxt.wbits + ASBC_CODE_BITS;
         s_nxt.last_fr = IN_FRAME;
      end
      // ----------------------------------------
      // Commands
      // ----------------------------------------
      if (CMD_VALID) begin
         if (CMD_CODE == ASBC_CMD_RELEASE) begin
            s_nxt.cmd_rel = 1'b1;
         end else if (CMD_CODE == ASBC_CMD_ASSERT) begin
            s_nxt.cmd_rel = 1'b0;
         end
      end
      // ----------------------------------------
      // Register bus
      // ----------------------------------------
      clr = 3'h0;
      if (WR && ADDR == ASBC_OFS_STATUS) begin
         clr = WDATA[2:0];
      end
      if (WR && ADDR == ASBC_OFS_MASK) begin
         s_nxt.mask = WDATA[2:0];
      end
      // A new event beats a clear in the same cycle
      s_nxt.stat = (s_r.stat & ~clr) | ev;
      if (RD) begin
         unique case (ADDR)
            ASBC_OFS_STATUS: s_nxt.rdata = {29'h0, s_r.stat};
            ASBC_OFS_MASK: s_nxt.rdata = {29'h0, s_r.mask};
            ASBC_OFS_FILL: s_nxt.rdata = {11'h0, s_r.fill};
            ASBC_OFS_STATE: s_nxt.rdata = {19'h0, s_r.last_fr, s_r.res, s_r.ovf,
               s_r.cmd_rel, 2'(s_r.st)};
            default: s_nxt.rdata = 32'h0;
         endcase
      end
      // ----------------------------------------
      // Disable and local reset
      // ----------------------------------------
      if (!SHOCK_MODE_SELECT) begin
         s_nxt.st = ASBC_OFF;
         s_nxt.ovf = 1'b0;
         s_nxt.res = 1'b0;
         s_nxt.wr_ptr = 20'h0;
         s_nxt.rd_ptr = 20'h0;
         s_nxt.fill = 21'h0;
         s_nxt.wbits = 4'h0;
         s_nxt.rbits = 4'h0;
         s_nxt.re = 1'b0;
         s_nxt.we = 1'b0;
         s_nxt.pend = 1'b0;
         s_nxt.oval = 1'b0;
         s_nxt.epred = 16'h0;
         s_nxt.esh = 4'h0;
         s_nxt.dpred = 16'h0;
         s_nxt.dsh = 4'h0;
      end
      // Only the shock logic clears; command latch and bus read data survive
      // A tied-low pin must still let a release command through, or the block stays held
      if (as_rst) begin
         keep_rel = s_nxt.cmd_rel;
         keep_rd = s_nxt.rdata;
         s_nxt = '0;
         s_nxt.cmd_rel = keep_rel;
         s_nxt.rdata = keep_rd;
      end
   end

   // Chip reset clears everything, leaving the F5 (asserted) latch state
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign OUT_VALID = s_r.oval;
   assign OUT_SAMPLE = s_r.osmp;
   assign BUFFER_OVERFLOW = s_r.ovf;
   assign RESUME_FOUND = s_r.res;
   assign DRAM_ADDR = s_r.addr;
   assign DRAM_WDATA = s_r.wdat;
   assign DRAM_WE = s_r.we;
   assign DRAM_RE = s_r.re;
   assign RDATA = s_r.rdata;
   assign IRQ = |(s_r.stat & s_r.mask);
endmodule : asbc_top
`default_nettype wire

// *** pkg/asbc_pkg.sv ***
package asbc_pkg;
   // ----------------------------------------
   // Widths
   // ----------------------------------------
   localparam int ASBC_DAW = 20;
   localparam int ASBC_RAW = 4;
   localparam int ASBC_DW = 32;
   localparam int ASBC_FRW = 8;
   localparam int ASBC_EVW = 3;
   // ----------------------------------------
   // Buffer capacity in nibbles
   // ----------------------------------------
   localparam logic [20:0] ASBC_CAP_SMALL = 21'h040000;
   localparam logic [20:0] ASBC_CAP_LARGE = 21'h100000;
   // ----------------------------------------
   // Codec constants
   // ----------------------------------------
   localparam logic [3:0] ASBC_CODE_BITS = 4'h5;
   localparam logic [3:0] ASBC_NIB_BITS = 4'h4;
   localparam logic [3:0] ASBC_SH_MAX = 4'hb;
   localparam logic [3:0] ASBC_MAG_HI = 4'hc;
   localparam logic [3:0] ASBC_MAG_LO = 4'h2;
   // ----------------------------------------
   // Command codes
   // ----------------------------------------
   localparam logic [7:0] ASBC_CMD_RELEASE = 8'hf4;
   localparam logic [7:0] ASBC_CMD_ASSERT = 8'hf5;
   // ----------------------------------------
   // Register offsets and status bits
   // ----------------------------------------
   localparam logic [3:0] ASBC_OFS_STATUS = 4'h0;
   localparam logic [3:0] ASBC_OFS_MASK = 4'h1;
   localparam logic [3:0] ASBC_OFS_FILL = 4'h2;
   localparam logic [3:0] ASBC_OFS_STATE = 4'h3;
   localparam int ASBC_EV_OVF = 0;
   localparam int ASBC_EV_RES = 1;
   localparam int ASBC_EV_SHK = 2;
   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef enum logic [1:0] {ASBC_OFF, ASBC_WRITE, ASBC_HALT} asbc_st_e;
   typedef struct packed {
      asbc_st_e st;
      logic cmd_rel;
      logic ovf;
      logic res;
      logic [19:0] wr_ptr;
      logic [19:0] rd_ptr;
      logic [20:0] fill;
      logic [8:0] wacc;
      logic [3:0] wbits;
      logic [8:0] racc;
      logic [3:0] rbits;
      logic re;
      logic pend;
      logic we;
      logic [19:0] addr;
      logic [3:0] wdat;
      logic [15:0] epred;
      logic [3:0] esh;
      logic [15:0] dpred;
      logic [3:0] dsh;
      logic oval;
      logic [15:0] osmp;
      logic [7:0] last_fr;
      logic [2:0] stat;
      logic [2:0] mask;
      logic [31:0] rdata;
   } asbc_state_s;
endpackage : asbc_pkg

// *** test/asbc_dram_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module asbc_dram_model (
   input wire logic clk,
   input wire logic [asbc_pkg::ASBC_DAW-1:0] addr,
   input wire logic [3:0] wdata,
   input wire logic we,
   input wire logic re,
   output logic [3:0] rdata
);
   logic [3:0] mem_r [0:1048575];
   initial rdata = 4'h0;
   always @(posedge clk) begin
      if (we) begin
         mem_r[addr] <= wdata;
      end
      // Data stand one cycle only; stale values are inverted so no luck hides a late capture
      if (re) begin
         rdata <= mem_r[addr];
      end else begin
         rdata <= ~rdata;
      end
   end
endmodule : asbc_dram_model
`default_nettype wire

// *** test/asbc_top_properties.sv ***
`timescale 1ns/100ps
`default_nettype none
module asbc_top_properties
   import asbc_pkg::*;
(
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic SHOCK_MODE_SELECT,
   input wire logic DRAM_SIZE_SELECT,
   input wire logic WRITE_PERMISSION,
   input wire logic SHOCK_CTRL_RESET_N,
   input wire logic CMD_VALID,
   input wire logic [7:0] CMD_CODE,
   input wire logic OUT_READY,
   input wire logic OUT_VALID,
   input wire logic [15:0] OUT_SAMPLE,
   input wire logic BUFFER_OVERFLOW,
   input wire logic RESUME_FOUND,
   input wire logic [ASBC_DAW-1:0] DRAM_ADDR,
   input wire logic DRAM_WE,
   input wire logic DRAM_RE
);
   // ----
   // Shadow of the command latch, so no internal probe is needed
   // ----
   logic rel_r;
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         rel_r <= 1'b0;
      end else if (CMD_VALID && CMD_CODE == ASBC_CMD_RELEASE) begin
         rel_r <= 1'b1;
      end else if (CMD_VALID && CMD_CODE == ASBC_CMD_ASSERT) begin
         rel_r <= 1'b0;
      end
   end
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_N);
   a_mode_off_idle: assert property (!SHOCK_MODE_SELECT [*2] |=> !DRAM_WE)
      else $error("buffer written in mode off");
   a_read_spacing: assert property (DRAM_RE |=> !DRAM_RE)
      else $error("buffer reads too close");
   a_read_first: assert property (DRAM_RE |-> !DRAM_WE)
      else $error("read and write together");
   a_out_hold: assert property (OUT_VALID && !OUT_READY && SHOCK_MODE_SELECT &&
      SHOCK_CTRL_RESET_N |=> OUT_VALID && $stable(OUT_SAMPLE))
      else $error("output sample not held");
   a_small_range: assert property (DRAM_SIZE_SELECT && (DRAM_WE || DRAM_RE)
      |-> DRAM_ADDR[19:18] == 2'h0)
      else $error("address beyond small buffer");
   a_ovf_cause: assert property ($rose(BUFFER_OVERFLOW)
      |-> $past(SHOCK_MODE_SELECT) && !RESUME_FOUND)
      else $error("overflow rise without cause");
   a_halt_no_write: assert property (BUFFER_OVERFLOW && $past(BUFFER_OVERFLOW) |-> !DRAM_WE)
      else $error("write during overflow");
   a_resume_cause: assert property ($rose(RESUME_FOUND) |-> $past(WRITE_PERMISSION) &&
      $past(BUFFER_OVERFLOW) && !BUFFER_OVERFLOW)
      else $error("resume without permission");
   a_local_reset: assert property (!SHOCK_CTRL_RESET_N && !rel_r
      |=> !BUFFER_OVERFLOW && !RESUME_FOUND && !DRAM_WE && !OUT_VALID)
      else $error("local reset ignored");
endmodule : asbc_top_properties
bind asbc_top asbc_top_properties u_props (.CLK(CLK), .RST_N(RST_N),
   .SHOCK_MODE_SELECT(SHOCK_MODE_SELECT), .DRAM_SIZE_SELECT(DRAM_SIZE_SELECT),
   .WRITE_PERMISSION(WRITE_PERMISSION), .SHOCK_CTRL_RESET_N(SHOCK_CTRL_RESET_N),
   .CMD_VALID(CMD_VALID), .CMD_CODE(CMD_CODE), .OUT_READY(OUT_READY),
   .OUT_VALID(OUT_VALID), .OUT_SAMPLE(OUT_SAMPLE), .BUFFER_OVERFLOW(BUFFER_OVERFLOW),
   .RESUME_FOUND(RESUME_FOUND), .DRAM_ADDR(DRAM_ADDR), .DRAM_WE(DRAM_WE),
   .DRAM_RE(DRAM_RE));
`default_nettype wire

// *** test/testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import asbc_pkg::*;
   logic clk, rst_n, mode, size, wp, c2, srst_n, cmd_v, in_v, in_rdy, out_rdy, out_v;
   logic ovf, res, dwe, dre, wr, rd, irq;
   logic [7:0] cmd, frm, last_fr;
   logic [15:0] smp, out_smp;
   logic [19:0] daddr;
   logic [3:0] dwd, drd, addr;
   logic [31:0] wdata, rdata;
   integer failures = 0, tests_run = 0, cyc = 0, seed = 32'hfe11;
   integer nacc = 0, nwe = 0, nout = 0, a0, w0, k;
   integer nst = 0;
   logic [15:0] ep = 16'h0;
   logic [3:0] es = 4'h0;
   logic [15:0] exp_mem [0:511];
   asbc_top DUT (
      .CLK(clk), .RST_N(rst_n), .SHOCK_MODE_SELECT(mode), .DRAM_SIZE_SELECT(size),
      .WRITE_PERMISSION(wp), .C2_ERROR_FLAG(c2), .SHOCK_CTRL_RESET_N(srst_n),
      .CMD_VALID(cmd_v), .CMD_CODE(cmd), .IN_VALID(in_v), .IN_READY(in_rdy),
      .IN_SAMPLE(smp), .IN_FRAME(frm), .OUT_READY(out_rdy), .OUT_VALID(out_v),
      .OUT_SAMPLE(out_smp), .BUFFER_OVERFLOW(ovf), .RESUME_FOUND(res),
      .DRAM_ADDR(daddr), .DRAM_WDATA(dwd), .DRAM_WE(dwe), .DRAM_RE(dre),
      .DRAM_RDATA(drd), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
      .RDATA(rdata), .IRQ(irq)
   );
   asbc_dram_model u_dram (
      .clk(clk), .addr(daddr), .wdata(dwd), .we(dwe), .re(dre), .rdata(drd)
   );
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Reference coder: sign and clipped magnitude, step shift adapts on large or small codes
   function automatic logic [19:0] codec(input logic [15:0] p, input logic [3:0] sh,
      input logic [15:0] x);
      integer d, n, q, s;
      d = $signed(x) - $signed(p);
      n = ((d < 0) ? -d : d) >> sh;
      n = (n > 15) ? 15 : n;
      q = (d < 0) ? $signed(p) - (n << sh) : $signed(p) + (n << sh);
      q = (q > 32767) ? 32767 : ((q < -32768) ? -32768 : q);
      s = (n >= ASBC_MAG_HI && sh < ASBC_SH_MAX) ? sh + 1 : ((n <= ASBC_MAG_LO && sh != 0) ?
         sh - 1 : sh);
      return {4'(s), 16'(q)};
   endfunction : codec
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (dwe) nwe <= nwe + 1;
      if (in_v && in_rdy) nacc <= nacc + 1;
      // Model coder follows every sample accepted while mode is high and overflow is low, so not the one that resumes writing
      if (in_v && in_rdy && !ovf && mode) begin
         last_fr <= frm;
         {es, ep} <= codec(ep, es, smp);
         exp_mem[nst[8:0]] <= 16'(codec(ep, es, smp));
         nst <= nst + 1;
      end
      if (out_v && out_rdy) begin
         check(32'(out_smp), 32'(exp_mem[nout[8:0]]));
         nout <= nout + 1;
      end
      if (cyc == 5000) begin
         failures = failures + 1;
         summarize();
      end
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run = tests_run + 1;
      if (got !== exp) begin
         failures = failures + 1;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   // Strobe for one cycle, then one idle cycle in which read data stand
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      wr <= w;
      rd <= !w;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge clk);
   endtask : bus
   task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      check(rdata, exp);
   endtask : rdchk
   task automatic send(input logic [7:0] code);
      cmd_v <= 1'b1;
      cmd <= code;
      @(posedge clk);
      cmd_v <= 1'b0;
      @(posedge clk);
   endtask : send
   task automatic stream(input integer n);
      repeat (n) begin
         {smp, in_v, out_rdy} <= 18'($random(seed));
         @(posedge clk);
         if (in_v && in_rdy) frm <= frm + 8'h1;
      end
      in_v <= 1'b0;
      out_rdy <= 1'b0;
   endtask : stream
   task automatic summarize();
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : summarize
   // ----
   // Scenarios
   // ----
   initial begin
      {rst_n, mode, wp, c2, cmd_v, in_v, out_rdy, wr, rd} = '0;
      {srst_n, size} = 2'b11;
      {cmd, frm, smp, addr, wdata} = '0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rdchk(ASBC_OFS_STATE, 32'h0);
      rdchk(4'h9, 32'h0);
      bus(1'b1, ASBC_OFS_MASK, 32'h7);
      rdchk(ASBC_OFS_MASK, 32'h7);
      mode <= 1'b1;
      @(posedge clk);
      a0 = nacc;
      w0 = nwe;
      stream(300);
      repeat (40) @(posedge clk);
      check(32'(nwe - w0), 32'(((nacc - a0) * 5) / 4));
      check(32'(nout > 0), 32'h1);
      c2 <= 1'b1;
      @(posedge clk);
      c2 <= 1'b0;
      rdchk(ASBC_OFS_STATUS, 32'h5);
      check({ovf, res, irq}, 32'h5);
      w0 = nwe;
      stream(60);
      repeat (4) @(posedge clk);
      check(32'(nwe - w0), 32'h0);
      bus(1'b1, ASBC_OFS_STATUS, 32'h1);
      rdchk(ASBC_OFS_STATUS, 32'h4);
      bus(1'b1, ASBC_OFS_MASK, 32'h3);
      check(irq, 32'h0);
      bus(1'b1, ASBC_OFS_STATUS, 32'h4);
      rdchk(ASBC_OFS_STATUS, 32'h0);
      // No permission first, then six passes that miss the stop point, then a retry that hits it
      in_v <= 1'b1;
      for (k = 0; k < 9; k++) begin
         wp <= (k != 0);
         frm <= last_fr + 8'((k == 0) ? 1 : ((k < 4) ? k + 1 : k - 6));
         @(posedge clk);
         // Outputs seen here answer the previous pass of the loop
         if (k > 0) check({ovf, res}, (k == 8) ? 32'h1 : 32'h2);
      end
      in_v <= 1'b0;
      wp <= 1'b0;
      srst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rdchk(ASBC_OFS_MASK, 32'h0);
      check({ovf, res}, 32'h0);
      send(ASBC_CMD_RELEASE);
      bus(1'b1, ASBC_OFS_MASK, 32'h7);
      rdchk(ASBC_OFS_MASK, 32'h7);
      send(8'h01);
      rdchk(ASBC_OFS_STATE, 32'h5);
      send(ASBC_CMD_ASSERT);
      rdchk(ASBC_OFS_MASK, 32'h0);
      srst_n <= 1'b1;
      send(ASBC_CMD_RELEASE);
      mode <= 1'b0;
      repeat (2) @(posedge clk);
      rdchk(ASBC_OFS_STATE, 32'h4);
      rst_n <= 1'b0;
      @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rdchk(ASBC_OFS_STATE, 32'h0);
      summarize();
   end
endmodule : testbench
`default_nettype wire
